// ### gpd_pkg.sv
package gpd_pkg;
  // ==========================================================
  // Register indexes; each register's bus address is four times its index.
  localparam logic [7:0] ADDR_P0_DRAIN  = 8'h9c;
  localparam logic [7:0] ADDR_P1_DRAIN  = 8'h9d;
  localparam logic [7:0] ADDR_P0_LATCH  = 8'ha6;
  localparam logic [7:0] ADDR_P1_LATCH  = 8'ha7;
  localparam logic [7:0] ADDR_P4_LATCH  = 8'haa;
  localparam logic [7:0] ADDR_P5_LATCH  = 8'hab;
  localparam logic [7:0] ADDR_P4_ACFG   = 8'hc6;
  localparam logic [7:0] ADDR_P5_ACFG   = 8'hc7;
  localparam logic [7:0] ADDR_CONV_MODE = 8'hc8;
  localparam logic [7:0] ADDR_P0_DIR    = 8'ha0;
  localparam logic [7:0] ADDR_P1_DIR    = 8'ha1;
  localparam logic [7:0] ADDR_P4_DIR    = 8'ha4;
  localparam logic [7:0] ADDR_P5_DIR    = 8'ha5;
  localparam logic [7:0] ADDR_P0_PULL   = 8'hac;
  localparam logic [7:0] ADDR_P1_PULL   = 8'had;
  localparam logic [7:0] ADDR_P4_PULL   = 8'hb0;
  localparam logic [7:0] ADDR_P5_PULL   = 8'hb1;
  // ==========================================================
  // Implemented bit masks and reset value
  localparam logic [7:0] MASK_P0       = 8'h7f;
  localparam logic [7:0] MASK_P1       = 8'hff;
  localparam logic [7:0] MASK_P4       = 8'hff;
  localparam logic [7:0] MASK_P5       = 8'h0f;
  localparam logic [7:0] MASK_P0_DRAIN = 8'h03;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  // Port 0 pin of the reset-shared bit and drain pin base.
  localparam int         RESET_PIN_BIT = 4;
  localparam int         P0_DRAIN_BASE = 2;
  // Converter mode fields.
  localparam int         ROUTE_EN_BIT  = 4;
  localparam int         CHAN_MSB      = 3;
  localparam int         P4_PINS       = 8;
  localparam int         P5_PINS       = 4;
  localparam int         NUM_CHANNELS  = 12;
endpackage : gpd_pkg

// ### gpd_port.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gpd_port
  import gpd_pkg::*;
(
  input  wire logic        mclk,          // Core clock, 10 MHz
  input  wire logic        rst_b,         // Asynchronous reset, low
  input  wire logic        reset_pin_opt, // External reset option on
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB write
  input  wire logic [31:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic [7:0]  p0_in,         // Port 0 pin levels
  input  wire logic [7:0]  p1_in,         // Port 1 pin levels
  input  wire logic [7:0]  p4_in,         // Port 4 pin levels
  input  wire logic [7:0]  p5_in,         // Port 5 pin levels
  output logic      [7:0]  p0_out,        // Port 0 drive level
  output logic      [7:0]  p1_out,        // Port 1 drive level
  output logic      [7:0]  p4_out,        // Port 4 drive level
  output logic      [7:0]  p5_out,        // Port 5 drive level
  output logic      [7:0]  p0_oe,         // Port 0 driving
  output logic      [7:0]  p1_oe,         // Port 1 driving
  output logic      [7:0]  p4_oe,         // Port 4 driving
  output logic      [7:0]  p5_oe,         // Port 5 driving
  output logic      [7:0]  p0_pull,       // Port 0 pull-up on
  output logic      [7:0]  p1_pull,       // Port 1 pull-up on
  output logic      [7:0]  p4_pull,       // Port 4 pull-up on
  output logic      [7:0]  p5_pull,       // Port 5 pull-up on
  output logic      [7:0]  p4_analog,     // Port 4 analog switch on
  output logic      [7:0]  p5_analog,     // Port 5 analog switch on
  output logic             analog_valid,  // A channel is routed
  output logic      [3:0]  analog_input_channel // Routed channel
);

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // Register state
  logic [7:0] port_zero_latch;
  logic [7:0] port_one_latch;
  logic [7:0] port_four_latch;
  logic [7:0] port_five_latch;
  logic [7:0] port_four_analog_cfg;
  logic [7:0] port_five_analog_cfg;
  logic [7:0] converter_mode_ctl;
  logic [7:0] port0_drain_ctl;
  logic [7:0] port1_drain_ctl;
  logic [7:0] p0_dir;
  logic [7:0] p1_dir;
  logic [7:0] p4_dir;
  logic [7:0] p5_dir;
  logic [7:0] p0_pu;
  logic [7:0] p1_pu;
  logic [7:0] p4_pu;
  logic [7:0] p5_pu;

  logic       wr_en;
  logic [7:0] wbyte;

  assign wr_en = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];

  // Each register is one aligned word at four times its index, so a
  // misaligned or out-of-window address never aliases onto a register.
  function automatic logic hit(input logic [31:0] a, input logic [7:0] r);
    hit = (a == {22'h0, r, 2'b00});
  endfunction : hit

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      port_zero_latch <= RESET_BYTE;
      port_one_latch  <= RESET_BYTE;
      port_four_latch <= RESET_BYTE;
      port_five_latch <= RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, ADDR_P0_LATCH))
        port_zero_latch <= wbyte & MASK_P0;
      else if (hit(paddr, ADDR_P1_LATCH))
        port_one_latch <= wbyte & MASK_P1;
      else if (hit(paddr, ADDR_P4_LATCH))
        port_four_latch <= wbyte & MASK_P4;
      else if (hit(paddr, ADDR_P5_LATCH))
        port_five_latch <= wbyte & MASK_P5;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      port_four_analog_cfg <= RESET_BYTE;
      port_five_analog_cfg <= RESET_BYTE;
      converter_mode_ctl   <= RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, ADDR_P4_ACFG))
        port_four_analog_cfg <= wbyte & MASK_P4;
      else if (hit(paddr, ADDR_P5_ACFG))
        port_five_analog_cfg <= wbyte & MASK_P5;
      else if (hit(paddr, ADDR_CONV_MODE))
        converter_mode_ctl <= wbyte;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      port0_drain_ctl <= RESET_BYTE;
      port1_drain_ctl <= RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, ADDR_P0_DRAIN))
        port0_drain_ctl <= wbyte & MASK_P0_DRAIN;
      else if (hit(paddr, ADDR_P1_DRAIN))
        port1_drain_ctl <= wbyte & MASK_P1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      p0_dir <= RESET_BYTE;
      p1_dir <= RESET_BYTE;
      p4_dir <= RESET_BYTE;
      p5_dir <= RESET_BYTE;
      p0_pu  <= RESET_BYTE;
      p1_pu  <= RESET_BYTE;
      p4_pu  <= RESET_BYTE;
      p5_pu  <= RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, ADDR_P0_DIR))
        p0_dir <= wbyte & MASK_P0;
      else if (hit(paddr, ADDR_P1_DIR))
        p1_dir <= wbyte & MASK_P1;
      else if (hit(paddr, ADDR_P4_DIR))
        p4_dir <= wbyte & MASK_P4;
      else if (hit(paddr, ADDR_P5_DIR))
        p5_dir <= wbyte & MASK_P5;
      else if (hit(paddr, ADDR_P0_PULL))
        p0_pu <= wbyte & MASK_P0;
      else if (hit(paddr, ADDR_P1_PULL))
        p1_pu <= wbyte & MASK_P1;
      else if (hit(paddr, ADDR_P4_PULL))
        p4_pu <= wbyte & MASK_P4;
      else if (hit(paddr, ADDR_P5_PULL))
        p5_pu <= wbyte & MASK_P5;
    end
  end

  // ==========================================================
  // Analog channel routing
  logic       analog_route_enable;
  logic [3:0] analog_channel_select;
  logic [15:0] chan_onehot;

  assign analog_route_enable   = converter_mode_ctl[ROUTE_EN_BIT];
  assign analog_channel_select = converter_mode_ctl[CHAN_MSB:0];

  // binary decode, one pin at most
  always_comb
  begin
    chan_onehot = 16'h0000;
    if (analog_route_enable)
      chan_onehot[analog_channel_select] = 1'b1;
  end

  assign analog_valid = analog_route_enable
                      & (analog_channel_select < 4'(NUM_CHANNELS));
  assign analog_input_channel = analog_channel_select;
  assign p4_analog = chan_onehot[P4_PINS-1:0];
  assign p5_analog = {4'h0, chan_onehot[P4_PINS+P5_PINS-1:P4_PINS]};

  // ==========================================================
  // Pin drive
  logic [7:0] p4_force_in;
  logic [7:0] p5_force_in;
  logic [7:0] p0_od;
  logic [7:0] p0_dir_eff;
  logic [7:0] p4_dir_eff;
  logic [7:0] p5_dir_eff;

  // analog-config or routed pin forced to input
  assign p4_force_in = port_four_analog_cfg | p4_analog;
  assign p5_force_in = port_five_analog_cfg | p5_analog;
  assign p4_dir_eff  = p4_dir & ~p4_force_in;
  assign p5_dir_eff  = p5_dir & ~p5_force_in & MASK_P5;
  assign p0_dir_eff  = p0_dir & MASK_P0;

  // drain bits placed at pins 2 and 3
  assign p0_od = {4'h0, port0_drain_ctl[1:0], 2'b00};

  // open drain drives low only; direction bit untouched
  // so clearing the drain bit restores the previous mode.
  always_comb
  begin
    p0_out = port_zero_latch & ~p0_od;
    p0_oe  = p0_dir_eff & ~(p0_od & port_zero_latch);
    p1_out = port_one_latch & ~port1_drain_ctl;
    p1_oe  = p1_dir & ~(port1_drain_ctl & port_one_latch);
    p4_out = port_four_latch;
    p4_oe  = p4_dir_eff;
    p5_out = port_five_latch;
    p5_oe  = p5_dir_eff;
  end

  // pull-ups only on input-mode digital pins
  always_comb
  begin
    p0_pull = p0_pu & ~p0_dir_eff;
    p1_pull = p1_pu & ~p1_dir;
    p4_pull = p4_pu & ~p4_dir_eff & ~p4_force_in;
    p5_pull = p5_pu & ~p5_dir_eff & ~p5_force_in;
  end

  // ==========================================================
  // APB read path
  logic [7:0] rd_byte;
  logic       mapped;
  logic [7:0] p0_read;

  always_comb
  begin
    p0_read = p0_in & MASK_P0;
    if (reset_pin_opt)
      p0_read[RESET_PIN_BIT] = 1'b1;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    mapped  = 1'b1;
    if (hit(paddr, ADDR_P0_LATCH))
      rd_byte = p0_read;
    else if (hit(paddr, ADDR_P1_LATCH))
      rd_byte = p1_in & MASK_P1;
    else if (hit(paddr, ADDR_P4_LATCH))
      rd_byte = p4_in & MASK_P4;
    else if (hit(paddr, ADDR_P5_LATCH))
      rd_byte = p5_in & MASK_P5;
    else if (hit(paddr, ADDR_P4_ACFG))
      rd_byte = port_four_analog_cfg;
    else if (hit(paddr, ADDR_P5_ACFG))
      rd_byte = port_five_analog_cfg;
    else if (hit(paddr, ADDR_CONV_MODE))
      rd_byte = converter_mode_ctl;
    else if (hit(paddr, ADDR_P0_DRAIN))
      rd_byte = port0_drain_ctl;
    else if (hit(paddr, ADDR_P1_DRAIN))
      rd_byte = port1_drain_ctl;
    else if (hit(paddr, ADDR_P0_DIR))
      rd_byte = p0_dir;
    else if (hit(paddr, ADDR_P1_DIR))
      rd_byte = p1_dir;
    else if (hit(paddr, ADDR_P4_DIR))
      rd_byte = p4_dir;
    else if (hit(paddr, ADDR_P5_DIR))
      rd_byte = p5_dir;
    else if (hit(paddr, ADDR_P0_PULL))
      rd_byte = p0_pu;
    else if (hit(paddr, ADDR_P1_PULL))
      rd_byte = p1_pu;
    else if (hit(paddr, ADDR_P4_PULL))
      rd_byte = p4_pu;
    else if (hit(paddr, ADDR_P5_PULL))
      rd_byte = p5_pu;
    else
      mapped = 1'b0;
  end

  // Read data is registered in the setup cycle so the access
  // phase always completes in one cycle with stable data.
  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h000000, rd_byte};
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
      pslverr <= 1'b0;
    else if (psel && !penable)
      pslverr <= ~mapped;
  end

  assign pready = 1'b1;

endmodule : gpd_port
`default_nettype wire

// ### gpd_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checks on the bus answer and pin control at the block ports.
module gpd_port_chk
  import gpd_pkg::*;
(
  input wire logic        mclk,                 // Core clock
  input wire logic        rst_b,                // Reset, low
  input wire logic        reset_pin_opt,        // Reset option
  input wire logic        psel,                 // Bus select
  input wire logic        penable,              // Bus enable
  input wire logic        pwrite,               // Bus write
  input wire logic [31:0] paddr,                // Bus address
  input wire logic [31:0] pwdata,               // Bus write data
  input wire logic [31:0] prdata,               // Bus read data
  input wire logic        pready,               // Bus ready
  input wire logic        pslverr,              // Bus error
  input wire logic [7:0]  p4_out,               // Port 4 level
  input wire logic [7:0]  p4_oe,                // Port 4 driving
  input wire logic [7:0]  p4_pull,              // Port 4 pull-up
  input wire logic [7:0]  p4_analog,            // Port 4 analog
  input wire logic [7:0]  p5_analog,            // Port 5 analog
  input wire logic        analog_valid,         // Channel routed
  input wire logic [3:0]  analog_input_channel  // Channel field
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  ready_always_a: assert property (pready)
    else $error("pready low");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  err_unmapped_a: assert property (psel && !penable &&
    paddr[31:10] != 22'h0 |=> pslverr)
    else $error("unmapped access not flagged");
  reset_bit_a: assert property (reset_pin_opt && psel && !penable &&
    !pwrite && paddr == {22'h0, ADDR_P0_LATCH, 2'b00} |=>
    prdata[RESET_PIN_BIT])
    else $error("reset-shared bit read low");
  one_pin_a: assert property ($onehot0({p5_analog, p4_analog}))
    else $error("more than one analog pin");
  decode_ch_a: assert property (analog_valid |->
    {p5_analog[3:0], p4_analog} == 12'h1 << analog_input_channel)
    else $error("channel decode wrong");
  route_off_a: assert property (!analog_valid |->
    {p5_analog, p4_analog} == 16'h0)
    else $error("analog pin without routing");
  analog_input_a: assert property (
    (p4_analog & (p4_oe | p4_pull)) == 8'h0)
    else $error("routed pin not a bare input");
  pull_input_a: assert property ((p4_oe & p4_pull) == 8'h0)
    else $error("pull-up on output pin");
  mode_field_a: assert property (psel && penable && pwrite &&
    paddr == {22'h0, ADDR_CONV_MODE, 2'b00} |=>
    analog_input_channel == $past(pwdata[3:0]) &&
    analog_valid == ($past(pwdata[4]) && $past(pwdata[3:0]) < 4'hc))
    else $error("mode fields misplaced");
  latch_drive_a: assert property (psel && penable && pwrite &&
    paddr == {22'h0, ADDR_P4_LATCH, 2'b00} |=>
    ((p4_out ^ $past(pwdata[7:0])) & p4_oe) == 8'h0)
    else $error("latch not driven");
endmodule : gpd_port_chk
`default_nettype wire

// ### gpd_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Board side of one port: a source or a pull-up on each pin.
module gpd_pin_model
(
  input  wire logic [7:0] drv,     // Device drive level
  input  wire logic [7:0] oe,      // Device driving
  input  wire logic [7:0] ext_en,  // Board source on
  input  wire logic [7:0] ext_val, // Board source level
  output logic      [7:0] lvl      // Resolved pin level
);
  // board pull-up
  // A released pin rises through the board pull-up, so a drain output
  // reads high with nobody driving it.
  assign lvl = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
endmodule : gpd_pin_model
`default_nettype wire

// ### gpd_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the port block.
module gpd_port_tb;
  import gpd_pkg::*;
  typedef struct {logic [31:0] a; logic [7:0] q; logic e;} gpd_row_t;
  logic        mclk, rst_b, reset_pin_opt, psel, penable, pwrite, er;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr, analog_valid;
  logic [3:0]  analog_input_channel;
  logic [7:0]  p0_in, p1_in, p4_in, p5_in, p0_out, p1_out, p4_out, p5_out;
  logic [7:0]  p0_oe, p1_oe, p4_oe, p5_oe, p0_pull, p1_pull, p4_pull;
  logic [7:0]  p5_pull, p4_analog, p5_analog, rd;
  logic [7:0]  xen [4];
  logic [7:0]  xv [4];
  logic [11:0] m;
  int          n_mismatch, samples_checked;
  gpd_row_t    rows [7];

  gpd_port gpd_port_inst (.mclk(mclk), .rst_b(rst_b),
    .reset_pin_opt(reset_pin_opt), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p0_in(p0_in), .p1_in(p1_in),
    .p4_in(p4_in), .p5_in(p5_in), .p0_out(p0_out), .p1_out(p1_out),
    .p4_out(p4_out), .p5_out(p5_out), .p0_oe(p0_oe), .p1_oe(p1_oe),
    .p4_oe(p4_oe), .p5_oe(p5_oe), .p0_pull(p0_pull), .p1_pull(p1_pull),
    .p4_pull(p4_pull), .p5_pull(p5_pull), .p4_analog(p4_analog),
    .p5_analog(p5_analog), .analog_valid(analog_valid),
    .analog_input_channel(analog_input_channel));
  gpd_pin_model pin0_inst (.drv(p0_out), .oe(p0_oe), .ext_en(xen[0]),
    .ext_val(xv[0]), .lvl(p0_in));
  gpd_pin_model pin1_inst (.drv(p1_out), .oe(p1_oe), .ext_en(xen[1]),
    .ext_val(xv[1]), .lvl(p1_in));
  gpd_pin_model pin4_inst (.drv(p4_out), .oe(p4_oe), .ext_en(xen[2]),
    .ext_val(xv[2]), .lvl(p4_in));
  gpd_pin_model pin5_inst (.drv(p5_out), .oe(p5_oe), .ext_en(xen[3]),
    .ext_val(xv[3]), .lvl(p5_in));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask : chk

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // The extra edge lets the new register value reach the pin outputs.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {22'h0, a, 2'b00}, d);
    @(posedge mclk);
  endtask : wr

  // Pin levels reach the read data with no synchroniser; wait three edges before reading.
  task automatic rdp(input logic [7:0] a);
    repeat (3) @(posedge mclk);
    apb(1'b0, {22'h0, a, 2'b00}, 8'h00);
  endtask : rdp

  initial
  begin
    rst_b = 1'b0;
    reset_pin_opt = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    xen = '{default: 8'h00};
    xv = '{default: 8'h00};
    // Error rows first; an error row reads back zero because its unmapped read returns zero, so that check cannot show where its write went.
    rows = '{'{32'h0, 8'h00, 1'b1},
      '{{22'h1, ADDR_P1_DRAIN, 2'b00}, 8'h00, 1'b1},
      '{{22'h0, ADDR_P0_DRAIN, 2'b00}, MASK_P0_DRAIN, 1'b0},
      '{{22'h0, ADDR_P1_DRAIN, 2'b00}, 8'hff, 1'b0},
      '{{22'h0, ADDR_P4_ACFG, 2'b00}, MASK_P4, 1'b0},
      '{{22'h0, ADDR_P5_ACFG, 2'b00}, MASK_P5, 1'b0},
      '{{22'h0, ADDR_CONV_MODE, 2'b00}, 8'hff, 1'b0}};
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 8'h00);
      chk("reset value", 8'h00, rd);
      apb(1'b1, rows[i].a, 8'hff);
      apb(1'b0, rows[i].a, 8'h00);
      chk("read back", rows[i].q, rd);
      chk("slverr", rows[i].e, er);
      apb(1'b1, rows[i].a, 8'h00);
    end
    $display("register table done");
    wr(ADDR_P4_LATCH, 8'ha5);
    wr(ADDR_P4_DIR, 8'hff);
    chk("p4_oe", 8'hff, p4_oe);
    chk("p4_out", 8'ha5, p4_out);
    rdp(ADDR_P4_LATCH);
    chk("p4 pins out", 8'ha5, rd);
    wr(ADDR_P4_DIR, 8'h00);
    @(posedge mclk);
    xen[2] <= 8'hff;
    xv[2] <= 8'h3c;
    rdp(ADDR_P4_LATCH);
    chk("p4 pins in", 8'h3c, rd);
    xen[2] <= 8'h00;
    wr(ADDR_P4_PULL, 8'hff);
    wr(ADDR_P4_DIR, 8'h0f);
    wr(ADDR_P4_ACFG, 8'h11);
    chk("p4_oe cfg", 8'h0e, p4_oe);
    chk("p4_pull cfg", 8'he0, p4_pull);
    wr(ADDR_P4_ACFG, 8'h00);
    wr(ADDR_P4_DIR, 8'hff);
    wr(ADDR_P5_DIR, 8'h0f);
    for (int c = 0; c < 32; c++)
    begin
      wr(ADDR_CONV_MODE, c[7:0]);
      m = (c[4] && c[3:0] < 12) ? 12'h1 << c[3:0] : 12'h0;
      chk("analog", m, {p5_analog[3:0], p4_analog});
      chk("oe routed", 12'(~m), {p5_oe[3:0], p4_oe});
      chk("valid", m != 12'h0, analog_valid);
    end
    wr(ADDR_P5_LATCH, 8'hff);
    chk("p5_out", 8'h0f, p5_out);
    wr(ADDR_P5_PULL, 8'hff);
    wr(ADDR_P5_DIR, 8'h00);
    chk("p5_pull", 8'h0f, p5_pull);
    $display("analog routing done");
    wr(ADDR_P1_LATCH, 8'h5a);
    wr(ADDR_P1_DIR, 8'hff);
    wr(ADDR_P1_PULL, 8'hff);
    chk("p1_pull out", 8'h00, p1_pull);
    wr(ADDR_P1_DRAIN, 8'hff);
    chk("p1_oe drain", 8'ha5, p1_oe);
    chk("p1_out drain", 8'h00, p1_out);
    rdp(ADDR_P1_LATCH);
    chk("p1 pins", 8'h5a, rd);
    wr(ADDR_P1_DRAIN, 8'h00);
    chk("p1_oe back", 8'hff, p1_oe);
    chk("p1_out back", 8'h5a, p1_out);
    wr(ADDR_P0_LATCH, 8'h0c);
    wr(ADDR_P0_DIR, 8'h7f);
    wr(ADDR_P0_DRAIN, 8'hff);
    chk("p0_oe drain", 8'h73, p0_oe);
    chk("p0_out drain", 8'h00, p0_out);
    $display("open drain done");
    wr(ADDR_P0_DIR, 8'h00);
    wr(ADDR_P0_PULL, 8'hff);
    chk("p0_pull", 8'h7f, p0_pull);
    @(posedge mclk);
    xen[0] <= 8'hff;
    reset_pin_opt <= 1'b1;
    rdp(ADDR_P0_LATCH);
    chk("p0 reset bit", 8'h10, rd);
    reset_pin_opt <= 1'b0;
    rdp(ADDR_P0_LATCH);
    chk("p0 pins", 8'h00, rd);
    $display("reset-shared bit done");
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("p1_oe reset", 8'h00, p1_oe);
    rst_b <= 1'b1;
    rdp(ADDR_P1_DRAIN);
    chk("drain reset", 8'h00, rd);
    $display("second reset done");
    finish_test();
  end
endmodule : gpd_port_tb

bind gpd_port gpd_port_chk gpd_port_chk_inst (.mclk(mclk), .rst_b(rst_b),
  .reset_pin_opt(reset_pin_opt), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .p4_out(p4_out), .p4_oe(p4_oe),
  .p4_pull(p4_pull), .p4_analog(p4_analog), .p5_analog(p5_analog),
  .analog_valid(analog_valid),
  .analog_input_channel(analog_input_channel));
`default_nettype wire
